// [rsal_pkg.sv]
// Package for the remote target alias and link status register slice.
// Assumes byte-wide registers reached at their printed offsets.
package rsal_pkg;

    // Register offsets
    localparam logic [7:0] RSAL_OFF_RESET_CTRL = 8'h04;
    localparam logic [7:0] RSAL_OFF_TARGET_ADDR = 8'h07;
    localparam logic [7:0] RSAL_OFF_TARGET_ALIAS = 8'h08;
    localparam logic [7:0] RSAL_OFF_CRC_LOW = 8'h0a;
    localparam logic [7:0] RSAL_OFF_CRC_HIGH = 8'h0b;
    localparam logic [7:0] RSAL_OFF_STATUS = 8'h0c;

    // Field positions
    localparam int RSAL_BIT_CRC_CLEAR = 5;
    localparam int RSAL_ADDR_MSB = 7;
    localparam int RSAL_ADDR_LSB = 1;
    localparam int RSAL_ST_SELFTEST_ERR = 3;
    localparam int RSAL_ST_PCLK = 2;
    localparam int RSAL_ST_NORMAL_ERR = 1;
    localparam int RSAL_ST_LINK = 0;

    // Reset values
    localparam logic [6:0] RSAL_RST_ADDR = 7'h00;
    localparam logic [15:0] RSAL_RST_COUNT = 16'h0000;
    localparam logic [7:0] RSAL_RST_BYTE = 8'h00;
    localparam logic [7:0] RSAL_UNMAPPED_READ = 8'h00;

    // Number of links served
    localparam int RSAL_PORTS = 2;

    // Pixel clock presence check timing
    localparam int RSAL_CLK_PERIOD_NS = 20;
    localparam int RSAL_PCLK_WINDOW_NS = 10000;
    localparam int RSAL_PCLK_WINDOW_CYCLES =
        RSAL_PCLK_WINDOW_NS / RSAL_CLK_PERIOD_NS;
    localparam int RSAL_PCLK_MIN_EDGES = 50;
    localparam int RSAL_PCLK_MAX_EDGES = 240;

endpackage

// [rsal_pclk_detect.sv]
// Pixel clock presence detector.
// Assumes pclk_div is the pixel clock divided down below half of clk;
// it is asynchronous to clk and is synchronised here.
`timescale 1ns/1ns
`default_nettype none

module rsal_pclk_detect #(
    parameter int WINDOW_CYCLES = rsal_pkg::RSAL_PCLK_WINDOW_CYCLES,
    parameter int MIN_EDGES = rsal_pkg::RSAL_PCLK_MIN_EDGES,
    parameter int MAX_EDGES = rsal_pkg::RSAL_PCLK_MAX_EDGES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pclk_div,
    output logic pclk_valid
);

    // Refuse settings the counters cannot serve
    initial begin
        if (WINDOW_CYCLES < 2 || WINDOW_CYCLES > 65535 ||
            MIN_EDGES < 1 || MAX_EDGES < MIN_EDGES ||
            MAX_EDGES > 65535) begin
            $error("rsal_pclk_detect: bad window or edge limits");
        end
    end

    localparam logic [15:0] WIN_LAST = 16'(WINDOW_CYCLES - 1);
    localparam logic [15:0] EDGE_MIN = 16'(MIN_EDGES);
    localparam logic [15:0] EDGE_MAX = 16'(MAX_EDGES);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [15:0] win;
        logic [15:0] edges;
        logic valid;
    } rsal_pclk_state_type;

    rsal_pclk_state_type state_q;
    rsal_pclk_state_type state_d;

    // Edge count per window decides validity
    always_comb begin
        state_d = state_q;
        state_d.s1 = pclk_div;
        state_d.s2 = state_q.s1;
        state_d.s3 = state_q.s2;
        if (state_q.win == WIN_LAST) begin
            state_d.win = 16'h0000;
            state_d.edges = 16'h0000;
            // A silent window keeps the old verdict; a dead input is
            // indistinguishable from a paused one at this point
            if (state_q.edges != 16'h0000) begin
                state_d.valid = (state_q.edges >= EDGE_MIN) &&
                    (state_q.edges <= EDGE_MAX);
            end
        end else begin
            state_d.win = state_q.win + 16'h0001;
            if (state_q.s2 && !state_q.s3 && state_q.edges != 16'hffff) begin
                state_d.edges = state_q.edges + 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pclk_valid = state_q.valid;

endmodule // rsal_pclk_detect

`default_nettype wire

// [rsal_regs.sv]
// Remote target alias, back-channel CRC counter and link status registers.
// Assumes a byte register port decoded by the serial control slave, and
// per-link event pulses from back-channel logic on the same clock.
//
// Functional notes
// - Remote target address kept in bits 7:1 at offset 0x07, bit 0 reserved.
// - Accesses to the alias are forwarded with the stored target address.
// - Alias address kept in bits 7:1 at offset 0x08, bit 0 reserved.
// - A zero target or zero alias blocks forwarding to that target.
// - Secondary port select steers per-port fields to the second link.
// - Read-only 16-bit CRC error count, low byte 0x0A, high 0x0B.
// - Both count bytes held at zero while clear bit 0x04[5] is set.
// - Status bit 3 flags CRC errors seen during self-test.
// - Self-test flag clears on link loss, self-test restart or clear bit.
// - Status bit 2 shows a valid pixel clock at the video input.
// - Pixel clock bit stays set until an out-of-range clock appears.
// - Status bit 1 flags CRC errors during normal operation.
// - Normal flag clears on link loss or while clear bit is set.
// - Status bit 0 shows cable link presence.
// - Clear bit does not self-clear; software writes zero to resume.
`timescale 1ns/1ns
`default_nettype none

module rsal_regs #(
    parameter int PCLK_WINDOW_CYCLES = rsal_pkg::RSAL_PCLK_WINDOW_CYCLES,
    parameter int PCLK_MIN_EDGES = rsal_pkg::RSAL_PCLK_MIN_EDGES,
    parameter int PCLK_MAX_EDGES = rsal_pkg::RSAL_PCLK_MAX_EDGES
) (
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic secondary_port_select,
    // Local transaction address to be checked for remapping
    input wire logic [6:0] local_addr,
    input wire logic local_addr_valid,
    output logic fwd_valid,
    output logic [1:0] fwd_hit,
    output logic [6:0] fwd_addr_0,
    output logic [6:0] fwd_addr_1,
    // Per-link back-channel events
    input wire logic [1:0] backchannel_crc_error,
    input wire logic [1:0] selftest_active,
    input wire logic [1:0] selftest_start,
    input wire logic [1:0] link_detect_pin,
    input wire logic pclk_div,
    output logic crc_clear_active
);

    localparam int NP = rsal_pkg::RSAL_PORTS;

    // Saturating increment of a back-channel error count
    function automatic logic [15:0] rsal_sat_inc(input logic [15:0] v);
        rsal_sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    // Field extraction from an address byte
    function automatic logic [6:0] rsal_addr_field(input logic [7:0] b);
        rsal_addr_field = b[rsal_pkg::RSAL_ADDR_MSB:rsal_pkg::RSAL_ADDR_LSB];
    endfunction

    typedef struct packed {
        logic [NP-1:0][6:0] target;
        logic [NP-1:0][6:0] alias_addr;
        logic [NP-1:0][15:0] count;
        logic [NP-1:0] selftest_crc_error_flag;
        logic [NP-1:0] normal_err;
        logic [NP-1:0] link_s1;
        logic [NP-1:0] link_s2;
        logic [NP-1:0] link_s3;
        logic [NP-1:0] link;
        logic clear;
        logic [7:0] rdata;
        logic fwd_valid;
        logic [NP-1:0] fwd_hit;
        logic [NP-1:0][6:0] fwd_addr;
    } rsal_regs_state_type;

    rsal_regs_state_type state_q;
    rsal_regs_state_type state_d;
    logic pclk_valid;
    logic port;

    // Pixel clock presence lives in its own detector
    rsal_pclk_detect #(
        .WINDOW_CYCLES(PCLK_WINDOW_CYCLES),
        .MIN_EDGES(PCLK_MIN_EDGES),
        .MAX_EDGES(PCLK_MAX_EDGES)
    ) u_pclk (
        .clk(clk),
        .rst_b(rst_b),
        .pclk_div(pclk_div),
        .pclk_valid(pclk_valid)
    );

    assign port = secondary_port_select;

    // Next-state logic for every register
    always_comb begin
        state_d = state_q;

        // Link presence: three stages, change taken when the last two agree
        state_d.link_s1 = link_detect_pin;
        state_d.link_s2 = state_q.link_s1;
        state_d.link_s3 = state_q.link_s2;
        for (int p = 0; p < NP; p++) begin
            if (state_q.link_s2[p] == state_q.link_s3[p]) begin
                state_d.link[p] = state_q.link_s3[p];
            end
        end

        // Counters and sticky error flags per link
        for (int p = 0; p < NP; p++) begin
            if (backchannel_crc_error[p]) begin
                state_d.count[p] = rsal_sat_inc(state_q.count[p]);
                if (selftest_active[p]) begin
                    state_d.selftest_crc_error_flag[p] = 1'b1;
                end else begin
                    state_d.normal_err[p] = 1'b1;
                end
            end
            // Clear wins here: the flags report the current link only
            if (selftest_start[p] || !state_q.link[p] || state_q.clear) begin
                state_d.selftest_crc_error_flag[p] = 1'b0;
            end
            if (!state_q.link[p] || state_q.clear) begin
                state_d.normal_err[p] = 1'b0;
            end
            if (state_q.clear) begin
                state_d.count[p] = rsal_pkg::RSAL_RST_COUNT;
            end
        end

        // Register writes; reserved bit 0 of address bytes is dropped
        if (reg_wr) begin
            unique case (reg_addr)
                rsal_pkg::RSAL_OFF_RESET_CTRL: begin
                    // Level stays until software writes zero
                    state_d.clear =
                        reg_wdata[rsal_pkg::RSAL_BIT_CRC_CLEAR];
                end
                rsal_pkg::RSAL_OFF_TARGET_ADDR: begin
                    state_d.target[port] = rsal_addr_field(reg_wdata);
                end
                rsal_pkg::RSAL_OFF_TARGET_ALIAS: begin
                    state_d.alias_addr[port] =
                        rsal_addr_field(reg_wdata);
                end
                default: begin
                    // Read-only or unmapped offsets ignore writes
                end
            endcase
        end

        // Register reads, answered one cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                rsal_pkg::RSAL_OFF_RESET_CTRL: begin
                    state_d.rdata = 8'h00;
                    state_d.rdata[rsal_pkg::RSAL_BIT_CRC_CLEAR] =
                        state_q.clear;
                end
                rsal_pkg::RSAL_OFF_TARGET_ADDR: begin
                    state_d.rdata = {state_q.target[port], 1'b0};
                end
                rsal_pkg::RSAL_OFF_TARGET_ALIAS: begin
                    state_d.rdata = {state_q.alias_addr[port], 1'b0};
                end
                rsal_pkg::RSAL_OFF_CRC_LOW: begin
                    state_d.rdata = state_q.count[port][7:0];
                end
                rsal_pkg::RSAL_OFF_CRC_HIGH: begin
                    state_d.rdata = state_q.count[port][15:8];
                end
                rsal_pkg::RSAL_OFF_STATUS: begin
                    state_d.rdata = 8'h00;
                    state_d.rdata[rsal_pkg::RSAL_ST_SELFTEST_ERR] =
                        state_q.selftest_crc_error_flag[port];
                    state_d.rdata[rsal_pkg::RSAL_ST_PCLK] = pclk_valid;
                    state_d.rdata[rsal_pkg::RSAL_ST_NORMAL_ERR] =
                        state_q.normal_err[port];
                    state_d.rdata[rsal_pkg::RSAL_ST_LINK] =
                        state_q.link[port];
                end
                default: begin
                    state_d.rdata = rsal_pkg::RSAL_UNMAPPED_READ;
                end
            endcase
        end

        // Alias match and remap for each link, one cycle after the request
        state_d.fwd_valid = local_addr_valid;
        for (int p = 0; p < NP; p++) begin
            // Zero in either field disables the target entirely
            state_d.fwd_hit[p] = local_addr_valid &&
                (state_q.target[p] != rsal_pkg::RSAL_RST_ADDR) &&
                (state_q.alias_addr[p] != rsal_pkg::RSAL_RST_ADDR) &&
                (local_addr == state_q.alias_addr[p]);
            if (state_d.fwd_hit[p]) begin
                state_d.fwd_addr[p] = state_q.target[p];
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = state_q.rdata;
    assign fwd_valid = state_q.fwd_valid;
    assign fwd_hit = state_q.fwd_hit;
    assign fwd_addr_0 = state_q.fwd_addr[0];
    assign fwd_addr_1 = state_q.fwd_addr[1];
    assign crc_clear_active = state_q.clear;

endmodule // rsal_regs

`default_nettype wire

// [rsal_far_side.sv]
// Far-side model: remote back channel, cable link and video source.
// Assumes the bench steers it with request levels on the block clock.
`timescale 1ns/1ns
`default_nettype none
module rsal_far_side (
    input wire logic clk,
    input wire logic [1:0] link_req,
    input wire logic [1:0] err_req,
    input wire logic [15:0] pclk_half,
    output logic [1:0] backchannel_crc_error,
    output logic [1:0] link_detect_pin,
    output logic pclk_div
);
    // Errors only arrive over a live link, one per requested cycle
    initial begin
        backchannel_crc_error = 2'h0;
        link_detect_pin = 2'h0;
        pclk_div = 1'b0;
    end
    always @(posedge clk) begin
        backchannel_crc_error <= err_req & link_req;
        link_detect_pin <= link_req;
    end
    // A removed video input stands still rather than toggling
    always begin
        if (pclk_half > 16'h0000) #(pclk_half) pclk_div = ~pclk_div;
        else #10 pclk_div = 1'b0;
    end
endmodule // rsal_far_side
`default_nettype wire

// [rsal_regs_asserts.sv]
// Checker for the alias and link status registers.
// Sees only the ports of rsal_regs; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module rsal_regs_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [6:0] local_addr,
    input wire logic local_addr_valid,
    input wire logic fwd_valid,
    input wire logic [1:0] fwd_hit,
    input wire logic [6:0] fwd_addr_0,
    input wire logic crc_clear_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Forwarding answers exactly one cycle after each request
    a_fwd_one_cycle: assert property (
        local_addr_valid |=> fwd_valid) else $error("forward answer missing");
    a_fwd_no_extra: assert property (
        !local_addr_valid |=> !fwd_valid) else $error("forward answer extra");
    a_fwd_addr_hold: assert property (
        $changed(fwd_addr_0) |-> fwd_hit[0]) else $error("remap moved");
    a_zero_no_hit: assert property (
        local_addr_valid && local_addr == 7'h00 |=> fwd_hit == 2'h0)
        else $error("zero address forwarded");
    a_clear_follow: assert property (
        reg_wr && reg_addr == 8'h04 |=> crc_clear_active == $past(reg_wdata[5]))
        else $error("clear bit not written");
    a_clear_stable: assert property (
        !(reg_wr && reg_addr == 8'h04) |=> $stable(crc_clear_active))
        else $error("clear bit changed alone");
    a_read_holds: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    // Two cycles of clear are needed before the count is surely zero
    a_count_cleared: assert property (
        crc_clear_active && $past(crc_clear_active) && reg_rd &&
        reg_addr[7:1] == 7'h05 |=> reg_rdata == 8'h00)
        else $error("count not cleared");
    a_status_rsvd: assert property (
        reg_rd && reg_addr == 8'h0c |=> reg_rdata[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_addr_bit0: assert property (
        reg_rd && reg_addr[7:1] == 7'h04 |=> !reg_rdata[0])
        else $error("reserved address bit set");
endmodule // rsal_regs_asserts
bind rsal_regs rsal_regs_asserts i_rsal_regs_asserts (.*);
`default_nettype wire

// [rsal_regs_tb_top.sv]
// Bench for rsal_regs with the far-side model and queued expectations.
// Assumes short pixel clock windows set through the design parameters.
`timescale 1ns/1ns
`default_nettype none
module rsal_regs_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic secondary_port_select = 1'b0, local_addr_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [6:0] local_addr = 7'h00, fwd_addr_0, fwd_addr_1, t0, t1, a0, a1;
    logic [1:0] selftest_active = 2'h0, selftest_start = 2'h0;
    logic [1:0] link_req = 2'h0, err_req = 2'h0, fwd_hit;
    logic [1:0] backchannel_crc_error, link_detect_pin;
    logic [15:0] pclk_half = 16'h0000;
    logic fwd_valid, pclk_div, crc_clear_active, rd_prev = 1'b0;
    logic [7:0] rq[$];
    logic [15:0] fq[$];
    logic [7:0] offs[7] = '{8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h04, 8'h20};
    int err_count = 0, check_count = 0, cyc = 0, n;

    rsal_regs #(.PCLK_WINDOW_CYCLES(20), .PCLK_MIN_EDGES(2),
        .PCLK_MAX_EDGES(8)) i_rsal_regs (.clk, .rst_b, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .secondary_port_select,
        .local_addr, .local_addr_valid, .fwd_valid, .fwd_hit, .fwd_addr_0,
        .fwd_addr_1, .backchannel_crc_error, .selftest_active,
        .selftest_start, .link_detect_pin, .pclk_div, .crc_clear_active);
    rsal_far_side i_rsal_far_side (.clk, .link_req, .err_req, .pclk_half,
        .backchannel_crc_error, .link_detect_pin, .pclk_div);

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Mismatches %0d of %0d comparisons", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Each strobe is one cycle wide and followed by an idle edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic fwd(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk);
        local_addr <= a;
        local_addr_valid <= 1'b1;
        fq.push_back(e);
        @(posedge clk);
        local_addr_valid <= 1'b0;
    endtask
    task automatic errs(input logic [1:0] m, input int k);
        repeat (k) @(posedge clk) err_req <= m;
        @(posedge clk) err_req <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Results land one cycle after their strobe; compare the oldest note
    always @(posedge clk) rd_prev <= reg_rd;
    always @(negedge clk) begin
        if (rd_prev) check(16'(reg_rdata), 16'(rq.pop_front()));
        if (fwd_valid) check({fwd_hit, fwd_addr_1, fwd_addr_0}, fq.pop_front());
        cyc++;
        if (cyc > 90000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h340a1a9d));
        t0 = 7'(1 + $urandom % 127);
        t1 = 7'(1 + $urandom % 127);
        a0 = 7'(1 + $urandom % 62);
        a1 = a0 + 7'h40;
        idle(16);
        rst_b <= 1'b1;
        foreach (offs[i]) rd(offs[i], 8'h00);
        // Per-port copies, reserved bit 0 and a read-only write
        wr(8'h07, {t0, 1'b1});
        wr(8'h08, {a0, 1'b1});
        secondary_port_select <= 1'b1;
        wr(8'h07, {t1, 1'b1});
        wr(8'h08, {a1, 1'b1});
        wr(8'h0a, 8'hff);
        rd(8'h07, {t1, 1'b0});
        rd(8'h08, {a1, 1'b0});
        rd(8'h0a, 8'h00);
        secondary_port_select <= 1'b0;
        rd(8'h07, {t0, 1'b0});
        fwd(a0, {2'b01, 7'h00, t0});
        fwd(a1, {2'b10, t1, t0});
        fwd(a0 + 7'h01, {2'b00, t1, t0});
        fwd(7'h00, {2'b00, t1, t0});
        secondary_port_select <= 1'b1;
        wr(8'h08, 8'h00);
        fwd(a1, {2'b00, t1, t0});
        // Link up, self-test errors on link 1, normal errors on link 0
        link_req <= 2'b11;
        idle(10);
        rd(8'h0c, 8'h01);
        selftest_active <= 2'b10;
        errs(2'b10, 2);
        rd(8'h0c, 8'h09);
        rd(8'h0a, 8'h02);
        selftest_active <= 2'b00;
        secondary_port_select <= 1'b0;
        n = 3 + $urandom % 4;
        errs(2'b01, n);
        rd(8'h0a, 8'(n));
        rd(8'h0b, 8'h00);
        rd(8'h0c, 8'h03);
        secondary_port_select <= 1'b1;
        selftest_start <= 2'b10;
        @(posedge clk) selftest_start <= 2'b00;
        idle(2);
        rd(8'h0c, 8'h01);
        // Clear holds while set, errors meanwhile are dropped
        wr(8'h04, 8'h20);
        errs(2'b11, 3);
        idle(10);
        rd(8'h0a, 8'h00);
        rd(8'h04, 8'h20);
        secondary_port_select <= 1'b0;
        rd(8'h0b, 8'h00);
        rd(8'h0c, 8'h01);
        wr(8'h04, 8'h00);
        errs(2'b01, 1);
        rd(8'h0a, 8'h01);
        link_req <= 2'b10;
        idle(10);
        rd(8'h0c, 8'h00);
        link_req <= 2'b11;
        // Pixel clock valid, then removed, then out of range
        pclk_half <= 16'd50;
        idle(80);
        rd(8'h0c, 8'h05);
        pclk_half <= 16'd0;
        idle(80);
        rd(8'h0c, 8'h05);
        pclk_half <= 16'd300;
        idle(100);
        rd(8'h0c, 8'h01);
        // Counter holds at its top instead of wrapping
        wr(8'h04, 8'h20);
        wr(8'h04, 8'h00);
        errs(2'b01, 65540);
        rd(8'h0a, 8'hff);
        rd(8'h0b, 8'hff);
        idle(3);
        test_done();
    end
endmodule // rsal_regs_tb_top
`default_nettype wire
